//--- rtl/ieu_defs.svh
`ifndef IEU_DEFS_SVH
`define IEU_DEFS_SVH

// iterations of the shared divider, one quotient bit each
`define IEU_DIV_STEPS 7'h40
// target of every recorded result other than a compare
`define IEU_FIRST_FIELD 3'h0
// positions inside a 4-bit condition field
`define IEU_FLD_LT 2'h3
`define IEU_FLD_GT 2'h2
`define IEU_FLD_EQ 2'h1
`define IEU_FLD_SO 2'h0
// most negative dividends, word sign-extended and doubleword
`define IEU_WORD_MIN 64'hFFFFFFFF80000000
`define IEU_DWORD_MIN 64'h8000000000000000
// reset value of the result data
`define IEU_RES_RST 64'h0

`endif

//--- rtl/ieu_pkg.sv
package ieu_pkg;

	typedef enum logic [6:0] {
		op_add, op_addc, op_adde, op_subf, op_subfc, op_subfe, op_addme, op_subfme,
		op_addze, op_subfze, op_neg, op_addi, op_addis, op_addic, op_addicr, op_subfic,
		op_mulli, op_mullw, op_mulld, op_mulhw, op_mulhwu, op_mulhd, op_mulhdu,
		op_divw, op_divwu, op_divd, op_divdu,
		op_cmp, op_cmpl, op_cmpi, op_cmpli,
		op_and, op_or, op_xor, op_nand, op_nor, op_eqv, op_andc, op_orc,
		op_andi, op_andis, op_ori, op_oris, op_xori, op_xoris,
		op_extsb, op_extsh, op_extsw, op_clzw, op_clzd,
		op_rldcl, op_rldcr, op_rldic, op_rldicl, op_rldicr, op_rldimi,
		op_rlwinm, op_rlwnm, op_rlwimi,
		op_sld, op_slw, op_srad, op_sradi, op_srd, op_srw, op_srawi, op_sraw
	} ieu_op_t;

	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_exec = 3'h2,
		st_div = 3'h4
	} ieu_state_t;

	typedef struct packed {
		ieu_op_t op;
		logic rec;
		logic oe;
		logic lng;
		logic [4:0] dst;
		logic [2:0] tgt;
		logic [15:0] imm;
		logic [5:0] rot_amt;
		logic [5:0] mbeg;
		logic [5:0] mend;
		logic [63:0] opa;
		logic [63:0] opb;
		logic [63:0] ops;
		logic so;
		logic ovf;
		logic cry;
	} ieu_inst_t;

endpackage

//--- rtl/ieu_divider.sv
`timescale 1ns/1ps
`include "ieu_defs.svh"

module ieu_divider
	import ieu_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [63:0] dividend,
	input wire logic [63:0] divisor,
	// answer
	output logic done_reg,
	output logic [63:0] quo_reg
);
	logic [63:0] rem_reg, rem_next, quo_next, dvs_reg, dvs_next;
	logic [6:0] cnt_reg, cnt_next;
	logic done_next;
	logic [65:0] trial;

	// restoring divide: slow but small, the unit stalls issue meanwhile
	always_comb begin
		rem_next = rem_reg;
		quo_next = quo_reg;
		dvs_next = dvs_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		trial = {1'b0, rem_reg, quo_reg[63]} - {2'h0, dvs_reg};
		if (start) begin
			rem_next = 64'h0;
			quo_next = dividend;
			dvs_next = divisor;
			cnt_next = `IEU_DIV_STEPS;
		end else if (cnt_reg != 7'h0) begin
			if (!trial[65]) begin
				rem_next = trial[63:0];
				quo_next = {quo_reg[62:0], 1'b1};
			end else begin
				rem_next = {rem_reg[62:0], quo_reg[63]};
				quo_next = {quo_reg[62:0], 1'b0};
			end
			cnt_next = cnt_reg - 7'h1;
			done_next = (cnt_reg == 7'h1);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rem_reg <= 64'h0;
			quo_reg <= 64'h0;
			dvs_reg <= 64'h0;
			cnt_reg <= 7'h0;
			done_reg <= 1'b0;
		end else begin
			rem_reg <= rem_next;
			quo_reg <= quo_next;
			dvs_reg <= dvs_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

endmodule // ieu_divider

//--- rtl/ieu_top.sv
// Implementation choices: the dispatch port and the placing of the registers.
`timescale 1ns/1ps
`include "ieu_defs.svh"

// Overview of operation
// - operands from register file, results to flags/fields
// - subtract-from computes b minus a
// - overflow flags only when overflow check set
// - flag-updating operations may stall following issue
// - compare a with unsigned_immediate, signed_immediate or b
// - signed compares algebraic, unsigned compares logical
// - compare result goes to chosen field
// - bit-parallel logical ops, shifted immediates upper half
// - record logical and andi forms set first field
// - logical ops leave exception flags unchanged
// - insert rotates keep destination where mask zero
// - rotate-and-mask ANDs rotated source with mask
// - immediate logical shifts done by rotates
// - word/doubleword shifts, algebraic by register or immediate
// - sign extension and leading-zero counts
// - multiply low and high, word and doubleword
// - signed/unsigned divides with overflow and record
// - record option updates condition field
// - overflow option enables overflow recording

module ieu_top
	import ieu_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// dispatch
	input wire logic issue_valid,
	input wire ieu_op_t issue_op,
	input wire logic record_en,
	input wire logic overflow_en,
	input wire logic cmp_long,
	input wire logic [4:0] dest_index,
	input wire logic [2:0] compare_target_field,
	input wire logic [15:0] immediate_field,
	input wire logic [5:0] rotate_amount_field,
	input wire logic [5:0] mask_begin,
	input wire logic [5:0] mask_end,
	// general_register_file read data
	input wire logic [63:0] source_reg_a,
	input wire logic [63:0] source_reg_b,
	input wire logic [63:0] store_src_reg,
	// fixed_point_exception_reg flags now
	input wire logic so_flag_in,
	input wire logic result_exceeded_flag_in,
	input wire logic propagated_borrow_flag_in,
	// completion
	output logic busy_reg,
	output logic res_valid_reg,
	// general_register_file write
	output logic gpr_we_reg,
	output logic [4:0] gpr_index_reg,
	output logic [63:0] gpr_data_reg,
	// fixed_point_exception_reg write
	output logic fxr_we_reg,
	output logic so_flag_reg,
	output logic result_exceeded_flag_reg,
	output logic propagated_borrow_flag_reg,
	// condition_register field write
	output logic cond_we_reg,
	output logic [2:0] cond_index_reg,
	output logic [3:0] cond_field_reg
);
	ieu_state_t state_reg, state_next;
	ieu_inst_t inst_reg, inst_next;
	logic div_neg_reg, div_neg_next, div_bad_reg, div_bad_next;
	logic busy_next, valid_next, gwe_next, fwe_next, so_next, ovf_next, cry_next, cwe_next;
	logic [4:0] gidx_next;
	logic [63:0] gdata_next;
	logic [2:0] cidx_next;
	logic [3:0] cval_next;
	logic div_start, div_done;
	logic [63:0] div_quo, dvd, dvs, q;
	logic [63:0] a, b, s, signed_immediate, unsigned_immediate, x, y, res, rot, msk, rw, aw, bw, sra_x, cmp_a, cmp_c;
	logic [64:0] sum, mul_a, mul_b;
	logic signed [129:0] prod;
	logic [6:0] shn;
	logic cin, ovf, cry, cry_we, ovf_cap, rec, wop, sgn, lt, gt, eq;
	logic is_div, is_cmp, is_logic;

	function automatic logic [63:0] gen_mask(input logic [5:0] mbg, input logic [5:0] mnd);
		logic [63:0] m;
		m = 64'h0;
		// bit 0 of the field numbering is the most significant bit
		for (int i = 0; i < 64; i++) begin
			if (mbg <= mnd) m[63-i] = (i >= mbg) && (i <= mnd);
			else m[63-i] = (i >= mbg) || (i <= mnd);
		end
		return m;
	endfunction

	function automatic logic [63:0] rotl(input logic [63:0] v, input logic [5:0] n);
		return (v << n) | (v >> (7'h40 - {1'b0, n}));
	endfunction

	function automatic logic [6:0] clz(input logic [63:0] v);
		logic [6:0] n;
		n = 7'h40;
		for (int i = 0; i < 64; i++) begin
			if (v[i]) n = 7'(63 - i);
		end
		return n;
	endfunction

	ieu_divider u_div (
		.core_clk(core_clk),
		.rst(rst),
		.start(div_start),
		.dividend(dvd[63] && sgn ? -dvd : dvd),
		.divisor(dvs[63] && sgn ? -dvs : dvs),
		.done_reg(div_done),
		.quo_reg(div_quo)
	);

	// datapath, always working on the held instruction
	always_comb begin
		a = inst_reg.opa;
		b = inst_reg.opb;
		s = inst_reg.ops;
		signed_immediate = {{48{inst_reg.imm[15]}}, inst_reg.imm};
		unsigned_immediate = {48'h0, inst_reg.imm};
		is_div = inst_reg.op inside {op_divw, op_divwu, op_divd, op_divdu};
		is_cmp = inst_reg.op inside {op_cmp, op_cmpl, op_cmpi, op_cmpli};
		is_logic = inst_reg.op inside {[op_and:op_clzd]};
		ovf_cap = inst_reg.op inside {[op_add:op_neg], op_mullw, op_mulld, [op_divw:op_divdu]};
		cry_we = inst_reg.op inside {op_addc, op_subfc, op_adde, op_subfe, op_addme, op_subfme,
			op_addze, op_subfze, op_addic, op_addicr, op_subfic, op_srad, op_sradi, op_srawi, op_sraw};
		rec = inst_reg.rec || inst_reg.op inside {op_andi, op_andis, op_addicr};
		// adder operand selection
		x = a;
		y = b;
		cin = 1'b0;
		case (inst_reg.op)
			op_subf, op_subfc: begin x = ~a; cin = 1'b1; end
			op_adde: cin = inst_reg.cry;
			op_subfe: begin x = ~a; cin = inst_reg.cry; end
			op_addme: begin y = '1; cin = inst_reg.cry; end
			op_subfme: begin x = ~a; y = '1; cin = inst_reg.cry; end
			op_addze: begin y = 64'h0; cin = inst_reg.cry; end
			op_subfze: begin x = ~a; y = 64'h0; cin = inst_reg.cry; end
			op_neg: begin x = ~a; y = 64'h0; cin = 1'b1; end
			op_addi, op_addic, op_addicr: y = signed_immediate;
			op_addis: y = {signed_immediate[47:0], 16'h0};
			op_subfic: begin x = ~a; y = signed_immediate; cin = 1'b1; end
			default: ;
		endcase
		sum = {1'b0, x} + {1'b0, y} + {64'h0, cin};
		// one signed 65x65 multiplier serves every multiply form
		wop = inst_reg.op inside {op_mullw, op_mulhw, op_mulhwu, op_divw, op_divwu};
		sgn = inst_reg.op inside {op_mulli, op_mullw, op_mulld, op_mulhw, op_mulhd, op_divw, op_divd,
			op_cmp, op_cmpi};
		aw = wop ? (sgn ? {{32{a[31]}}, a[31:0]} : {32'h0, a[31:0]}) : a;
		bw = wop ? (sgn ? {{32{b[31]}}, b[31:0]} : {32'h0, b[31:0]}) : b;
		if (inst_reg.op == op_mulli) bw = signed_immediate;
		mul_a = {sgn & aw[63], aw};
		mul_b = {sgn & bw[63], bw};
		prod = $signed(mul_a) * $signed(mul_b);
		dvd = aw;
		dvs = bw;
		// compare operands, word compares extend the low halves
		cmp_c = inst_reg.op == op_cmpi ? signed_immediate : (inst_reg.op == op_cmpli ? unsigned_immediate : b);
		cmp_a = a;
		if (!inst_reg.lng) begin
			cmp_a = sgn ? {{32{a[31]}}, a[31:0]} : {32'h0, a[31:0]};
			cmp_c = sgn ? {{32{cmp_c[31]}}, cmp_c[31:0]} : {32'h0, cmp_c[31:0]};
		end
		lt = sgn ? ($signed(cmp_a) < $signed(cmp_c)) : (cmp_a < cmp_c);
		gt = sgn ? ($signed(cmp_a) > $signed(cmp_c)) : (cmp_a > cmp_c);
		eq = cmp_a == cmp_c;
		// rotate source and mask
		rw = {s[31:0], s[31:0]};
		rot = rotl(s, inst_reg.rot_amt);
		msk = gen_mask(inst_reg.mbeg, 6'h3F);
		case (inst_reg.op)
			op_rldcl: rot = rotl(s, b[5:0]);
			op_rldcr: begin rot = rotl(s, b[5:0]); msk = gen_mask(6'h0, inst_reg.mend); end
			op_rldic, op_rldimi: msk = gen_mask(inst_reg.mbeg, 6'h3F - inst_reg.rot_amt);
			op_rldicr: msk = gen_mask(6'h0, inst_reg.mend);
			op_rlwinm, op_rlwimi: begin
				rot = rotl(rw, {1'b0, inst_reg.rot_amt[4:0]});
				msk = gen_mask({1'b1, inst_reg.mbeg[4:0]}, {1'b1, inst_reg.mend[4:0]});
			end
			op_rlwnm: begin
				rot = rotl(rw, {1'b0, b[4:0]});
				msk = gen_mask({1'b1, inst_reg.mbeg[4:0]}, {1'b1, inst_reg.mend[4:0]});
			end
			default: ;
		endcase
		// algebraic right shift, carry when a negative value loses ones
		sra_x = inst_reg.op inside {op_sraw, op_srawi} ? {{32{s[31]}}, s[31:0]} : s;
		case (inst_reg.op)
			op_sradi: shn = {1'b0, inst_reg.rot_amt};
			op_srawi: shn = {2'h0, inst_reg.rot_amt[4:0]};
			op_sraw: shn = {1'b0, b[5:0]};
			default: shn = b[6:0];
		endcase
		// divide result, fixed up for sign and for the bad cases
		q = div_neg_reg ? -div_quo : div_quo;
		res = 64'h0;
		ovf = 1'b0;
		cry = sum[64];
		case (inst_reg.op)
			op_add, op_addc, op_adde, op_subf, op_subfc, op_subfe, op_addme, op_subfme, op_addze,
			op_subfze, op_neg, op_addi, op_addis, op_addic, op_addicr, op_subfic: begin
				res = sum[63:0];
				ovf = (x[63] == y[63]) && (sum[63] != x[63]);
			end
			op_mulli, op_mulld: begin
				res = prod[63:0];
				ovf = !(&prod[127:63] || ~|prod[127:63]);
			end
			op_mullw: begin
				res = prod[63:0];
				ovf = !(&prod[63:31] || ~|prod[63:31]);
			end
			op_mulhw, op_mulhwu: res = {32'h0, prod[63:32]};
			op_mulhd, op_mulhdu: res = prod[127:64];
			op_divw, op_divwu, op_divd, op_divdu: begin
				res = div_bad_reg ? 64'h0 : (wop ? {32'h0, q[31:0]} : q);
				ovf = div_bad_reg;
			end
			op_and: res = s & b;
			op_or: res = s | b;
			op_xor: res = s ^ b;
			op_nand: res = ~(s & b);
			op_nor: res = ~(s | b);
			op_eqv: res = ~(s ^ b);
			op_andc: res = s & ~b;
			op_orc: res = s | ~b;
			op_andi: res = s & unsigned_immediate;
			op_andis: res = s & {unsigned_immediate[47:0], 16'h0};
			op_ori: res = s | unsigned_immediate;
			op_oris: res = s | {unsigned_immediate[47:0], 16'h0};
			op_xori: res = s ^ unsigned_immediate;
			op_xoris: res = s ^ {unsigned_immediate[47:0], 16'h0};
			op_extsb: res = {{56{s[7]}}, s[7:0]};
			op_extsh: res = {{48{s[15]}}, s[15:0]};
			op_extsw: res = {{32{s[31]}}, s[31:0]};
			op_clzw: res = {57'h0, clz({s[31:0], 32'hFFFFFFFF})};
			op_clzd: res = {57'h0, clz(s)};
			op_rldimi, op_rlwimi: res = (rot & msk) | (a & ~msk);
			op_rldcl, op_rldcr, op_rldic, op_rldicl, op_rldicr, op_rlwinm, op_rlwnm:
				res = rot & msk;
			op_sld: res = b[6] ? 64'h0 : s << b[5:0];
			op_slw: res = b[5] ? 64'h0 : {32'h0, s[31:0] << b[4:0]};
			op_srd: res = b[6] ? 64'h0 : s >> b[5:0];
			op_srw: res = b[5] ? 64'h0 : {32'h0, s[31:0] >> b[4:0]};
			op_srad, op_sradi, op_sraw, op_srawi: begin
				if (shn[6]) begin
					res = {64{sra_x[63]}};
					cry = sra_x[63] && |sra_x;
				end else begin
					res = $signed(sra_x) >>> shn[5:0];
					cry = sra_x[63] && |(sra_x & ~({64{1'b1}} << shn[5:0]));
				end
			end
			default: ;
		endcase
	end

	// sequencing and result registers
	always_comb begin
		state_next = state_reg;
		inst_next = inst_reg;
		div_neg_next = div_neg_reg;
		div_bad_next = div_bad_reg;
		div_start = 1'b0;
		valid_next = 1'b0;
		gwe_next = 1'b0;
		fwe_next = 1'b0;
		cwe_next = 1'b0;
		gidx_next = gpr_index_reg;
		gdata_next = gpr_data_reg;
		so_next = so_flag_reg;
		ovf_next = result_exceeded_flag_reg;
		cry_next = propagated_borrow_flag_reg;
		cidx_next = cond_index_reg;
		cval_next = cond_field_reg;
		unique case (state_reg)
			st_idle: begin
				if (issue_valid) begin
					inst_next = '{op: issue_op, rec: record_en, oe: overflow_en, lng: cmp_long,
						dst: dest_index, tgt: compare_target_field, imm: immediate_field,
						rot_amt: rotate_amount_field, mbeg: mask_begin, mend: mask_end,
						opa: source_reg_a, opb: source_reg_b, ops: store_src_reg,
						so: so_flag_in, ovf: result_exceeded_flag_in, cry: propagated_borrow_flag_in};
					state_next = st_exec;
				end
			end
			st_exec: begin
				if (is_div) begin
					div_start = 1'b1;
					div_neg_next = sgn && (dvd[63] != dvs[63]);
					div_bad_next = (dvs == 64'h0) || (sgn && dvs == '1 &&
						dvd == (wop ? `IEU_WORD_MIN : `IEU_DWORD_MIN));
					state_next = st_div;
				end else begin
					state_next = st_idle;
				end
			end
			st_div: begin
				if (div_done) state_next = st_idle;
			end
		endcase
		if ((state_reg == st_exec && !is_div) || (state_reg == st_div && div_done)) begin
			valid_next = 1'b1;
			gwe_next = !is_cmp;
			gidx_next = inst_reg.dst;
			gdata_next = res;
			// logical ops are masked off the flag write enable below
			fwe_next = !is_logic && ((inst_reg.oe && ovf_cap) || cry_we);
			ovf_next = (inst_reg.oe && ovf_cap) ? ovf : inst_reg.ovf;
			so_next = inst_reg.so || (inst_reg.oe && ovf_cap && ovf);
			cry_next = cry_we ? cry : inst_reg.cry;
			cwe_next = is_cmp || rec;
			if (is_cmp) begin
				cidx_next = inst_reg.tgt;
				cval_next[`IEU_FLD_LT] = lt;
				cval_next[`IEU_FLD_GT] = gt;
				cval_next[`IEU_FLD_EQ] = eq;
				cval_next[`IEU_FLD_SO] = inst_reg.so;
			end else begin
				cidx_next = `IEU_FIRST_FIELD;
				cval_next[`IEU_FLD_LT] = res[63];
				cval_next[`IEU_FLD_GT] = !res[63] && |res;
				cval_next[`IEU_FLD_EQ] = ~|res;
				cval_next[`IEU_FLD_SO] = so_next;
			end
		end
		busy_next = state_next != st_idle;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= st_idle;
			inst_reg <= '0;
			div_neg_reg <= 1'b0;
			div_bad_reg <= 1'b0;
			busy_reg <= 1'b0;
			res_valid_reg <= 1'b0;
			gpr_we_reg <= 1'b0;
			gpr_index_reg <= 5'h0;
			gpr_data_reg <= `IEU_RES_RST;
			fxr_we_reg <= 1'b0;
			so_flag_reg <= 1'b0;
			result_exceeded_flag_reg <= 1'b0;
			propagated_borrow_flag_reg <= 1'b0;
			cond_we_reg <= 1'b0;
			cond_index_reg <= 3'h0;
			cond_field_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			inst_reg <= inst_next;
			div_neg_reg <= div_neg_next;
			div_bad_reg <= div_bad_next;
			busy_reg <= busy_next;
			res_valid_reg <= valid_next;
			gpr_we_reg <= gwe_next;
			gpr_index_reg <= gidx_next;
			gpr_data_reg <= gdata_next;
			fxr_we_reg <= fwe_next;
			so_flag_reg <= so_next;
			result_exceeded_flag_reg <= ovf_next;
			propagated_borrow_flag_reg <= cry_next;
			cond_we_reg <= cwe_next;
			cond_index_reg <= cidx_next;
			cond_field_reg <= cval_next;
		end
	end

	hold_issue_a: assert property (@(posedge core_clk) disable iff (rst)
		issue_valid && !busy_reg && issue_op inside {[op_divw:op_divdu]} |=> busy_reg [*8] ##58 busy_reg ##1 !busy_reg)
		else $error("divide did not hold issue for its run");
	fast_done_a: assert property (@(posedge core_clk) disable iff (rst)
		issue_valid && !busy_reg && !(issue_op inside {[op_divw:op_divdu]}) |-> ##2 res_valid_reg)
		else $error("single-cycle result missing");
	div_done_a: assert property (@(posedge core_clk) disable iff (rst)
		issue_valid && !busy_reg && issue_op inside {[op_divw:op_divdu]} |-> ##67 res_valid_reg)
		else $error("divide result not on time");
	oe_guard_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && !inst_reg.oe |-> result_exceeded_flag_reg == inst_reg.ovf && so_flag_reg == inst_reg.so)
		else $error("overflow flags changed without check bit");
	subf_order_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && inst_reg.op == op_subf |-> gpr_data_reg == inst_reg.opb - inst_reg.opa)
		else $error("subtract operands reversed");
	logic_flags_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && is_logic |-> !fxr_we_reg)
		else $error("logical op wrote exception flags");
	cmp_target_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && is_cmp |-> cond_we_reg && cond_index_reg == inst_reg.tgt && !gpr_we_reg)
		else $error("compare field misdirected");
	rec_field_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && rec && !is_cmp |-> cond_we_reg && cond_index_reg == `IEU_FIRST_FIELD)
		else $error("record form missed first field");
	field_so_a: assert property (@(posedge core_clk) disable iff (rst)
		cond_we_reg && !is_cmp |-> cond_field_reg[`IEU_FLD_SO] == so_flag_reg)
		else $error("field summary copy wrong");
	andi_rec_a: assert property (@(posedge core_clk) disable iff (rst)
		res_valid_reg && inst_reg.op inside {op_andi, op_andis} |-> cond_we_reg)
		else $error("and-immediate did not record");

endmodule // ieu_top

//--- dv/ieu_dispatch.sv
`timescale 1ns/1ps

module ieu_dispatch
	import ieu_pkg::*;
(
	// clock and unit state
	input wire logic core_clk,
	input wire logic busy_reg,
	// dispatch
	output logic issue_valid,
	output ieu_op_t issue_op,
	output logic record_en,
	output logic overflow_en,
	output logic cmp_long,
	output logic [4:0] dest_index,
	output logic [2:0] compare_target_field,
	output logic [15:0] immediate_field,
	output logic [5:0] rotate_amount_field,
	output logic [5:0] mask_begin,
	output logic [5:0] mask_end,
	// register file and flag state
	output logic [63:0] source_reg_a,
	output logic [63:0] source_reg_b,
	output logic [63:0] store_src_reg,
	output logic so_flag_in,
	output logic result_exceeded_flag_in,
	output logic propagated_borrow_flag_in
);
	initial begin
		{issue_valid, record_en, overflow_en, cmp_long, dest_index, compare_target_field} = '0;
		{immediate_field, rotate_amount_field, mask_begin, mask_end} = '0;
		{source_reg_a, source_reg_b, store_src_reg} = '0;
		{so_flag_in, result_exceeded_flag_in, propagated_borrow_flag_in} = '0;
		issue_op = op_add;
	end

	// the unit drops offers made while busy, so the offer stays up until an idle edge
	task automatic send(input ieu_inst_t i);
		@(posedge core_clk);
		issue_valid <= 1'b1;
		issue_op <= i.op;
		record_en <= i.rec;
		overflow_en <= i.oe;
		cmp_long <= i.lng;
		dest_index <= i.dst;
		compare_target_field <= i.tgt;
		immediate_field <= i.imm;
		rotate_amount_field <= i.rot_amt;
		mask_begin <= i.mbeg;
		mask_end <= i.mend;
		source_reg_a <= i.opa;
		source_reg_b <= i.opb;
		store_src_reg <= i.ops;
		so_flag_in <= i.so;
		result_exceeded_flag_in <= i.ovf;
		propagated_borrow_flag_in <= i.cry;
		@(negedge core_clk);
		while (busy_reg) begin
			@(negedge core_clk);
		end
		@(posedge core_clk);
		issue_valid <= 1'b0;
		// operands released: show inverted data so a late sample cannot pass
		source_reg_a <= ~i.opa;
		source_reg_b <= ~i.opb;
		store_src_reg <= ~i.ops;
	endtask
endmodule // ieu_dispatch

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "ieu_defs.svh"

module testbench
	import ieu_pkg::*;
;
	logic core_clk, rst, busy_reg, res_valid_reg, gpr_we_reg, fxr_we_reg, cond_we_reg;
	logic so_flag_reg, result_exceeded_flag_reg, propagated_borrow_flag_reg;
	logic [4:0] gpr_index_reg;
	logic [63:0] gpr_data_reg;
	logic [2:0] cond_index_reg;
	logic [3:0] cond_field_reg;
	logic issue_valid, record_en, overflow_en, cmp_long;
	logic so_flag_in, result_exceeded_flag_in, propagated_borrow_flag_in;
	ieu_op_t issue_op;
	logic [4:0] dest_index;
	logic [2:0] compare_target_field;
	logic [15:0] immediate_field;
	logic [5:0] rotate_amount_field, mask_begin, mask_end;
	logic [63:0] source_reg_a, source_reg_b, store_src_reg;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int unsigned seed_val;
	ieu_op_t op_list[33] = '{op_add, op_subf, op_mulld, op_mulhdu, op_divd, op_divdu, op_cmp, op_cmpl,
		op_cmpi, op_cmpli, op_and, op_or, op_xor, op_nand, op_nor, op_eqv, op_andc, op_orc, op_andi,
		op_andis, op_ori, op_oris, op_extsb, op_extsw, op_clzd, op_rldicl, op_rldimi, op_srad,
		op_mullw, op_divw, op_divwu, op_sld, op_srw};

	ieu_dispatch disp_u (.*);
	ieu_top dut_u (.*);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic wrap_up;
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			wrap_up;
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run(input ieu_inst_t i);
		logic [127:0] p;
		logic [63:0] r, x, y, m, rot;
		logic ovf, cry, fxw, cw, sgn, cmpop, so_x;
		int lat, n;
		r = '0;
		ovf = 1'b0;
		cry = i.cry;
		fxw = 1'b0;
		cw = i.rec;
		lat = 2;
		cmpop = i.op inside {op_cmp, op_cmpl, op_cmpi, op_cmpli};
		rot = (i.ops << i.rot_amt) | (i.ops >> (7'h40 - i.rot_amt));
		case (i.op)
			op_add: begin
				r = i.opa + i.opb;
				ovf = (i.opa[63] == i.opb[63]) && (r[63] != i.opa[63]);
			end
			op_subf: begin
				r = i.opb - i.opa;
				ovf = (i.opa[63] != i.opb[63]) && (r[63] != i.opb[63]);
			end
			op_mulld: begin
				p = {{64{i.opa[63]}}, i.opa} * {{64{i.opb[63]}}, i.opb};
				r = p[63:0];
				ovf = p[127:63] != {65{p[63]}};
			end
			op_mulhdu: begin
				p = {64'h0, i.opa} * {64'h0, i.opb};
				r = p[127:64];
			end
			op_divd, op_divdu: begin
				lat = 67;
				ovf = (i.opb == 64'h0) || (i.op == op_divd && i.opa == `IEU_DWORD_MIN && i.opb == ~64'h0);
				// kept apart: one shared conditional would turn the signed quotient unsigned
				if (!ovf && i.op == op_divd) r = $signed(i.opa) / $signed(i.opb);
				if (!ovf && i.op == op_divdu) r = i.opa / i.opb;
			end
			op_mullw: begin
				p = {{96{i.opa[31]}}, i.opa[31:0]} * {{96{i.opb[31]}}, i.opb[31:0]};
				r = p[63:0];
				ovf = p[63:31] != {33{p[31]}};
			end
			op_divw, op_divwu: begin
				lat = 67;
				ovf = (i.opb[31:0] == 32'h0) || (i.op == op_divw && i.opa[31:0] == 32'h80000000
					&& i.opb[31:0] == 32'hFFFFFFFF);
				if (!ovf && i.op == op_divw) r = {32'h0, 32'($signed(i.opa[31:0]) / $signed(i.opb[31:0]))};
				if (!ovf && i.op == op_divwu) r = {32'h0, i.opa[31:0] / i.opb[31:0]};
			end
			op_sld: r = i.ops << i.opb[6:0];
			op_srw: r = {32'h0, i.ops[31:0]} >> i.opb[5:0];
			op_and: r = i.ops & i.opb;
			op_or: r = i.ops | i.opb;
			op_xor: r = i.ops ^ i.opb;
			op_nand: r = ~(i.ops & i.opb);
			op_nor: r = ~(i.ops | i.opb);
			op_eqv: r = ~(i.ops ^ i.opb);
			op_andc: r = i.ops & ~i.opb;
			op_orc: r = i.ops | ~i.opb;
			op_andi: r = i.ops & {48'h0, i.imm};
			op_andis: r = i.ops & {32'h0, i.imm, 16'h0};
			op_ori: r = i.ops | {48'h0, i.imm};
			op_oris: r = i.ops | {32'h0, i.imm, 16'h0};
			op_extsb: r = {{56{i.ops[7]}}, i.ops[7:0]};
			op_extsw: r = {{32{i.ops[31]}}, i.ops[31:0]};
			op_clzd: begin
				r = 64'h40;
				for (int k = 0; k < 64; k++) begin
					if (i.ops[k]) r = 63 - k;
				end
			end
			op_rldicl: r = rot & (~64'h0 >> i.mbeg);
			op_rldimi: begin
				m = (i.mbeg <= 63 - i.rot_amt) ? ((~64'h0 >> i.mbeg) & (~64'h0 << i.rot_amt))
					: ((~64'h0 >> i.mbeg) | (~64'h0 << i.rot_amt));
				r = (rot & m) | (i.opa & ~m);
			end
			op_srad: begin
				r = $signed(i.ops) >>> i.opb[6:0];
				cry = i.ops[63] && ((r << i.opb[6:0]) != i.ops);
				fxw = 1'b1;
			end
			default: ;
		endcase
		if (i.op inside {op_add, op_subf, op_mulld, op_divd, op_divdu, op_mullw, op_divw, op_divwu}) fxw = i.oe;
		so_x = i.so | (i.oe && ovf);
		x = i.opa;
		y = (i.op == op_cmpi) ? {{48{i.imm[15]}}, i.imm} : (i.op == op_cmpli) ? {48'h0, i.imm} : i.opb;
		sgn = i.op inside {op_cmp, op_cmpi};
		if (!i.lng) begin
			x = sgn ? {{32{x[31]}}, x[31:0]} : {32'h0, x[31:0]};
			y = sgn ? {{32{y[31]}}, y[31:0]} : {32'h0, y[31:0]};
		end
		if (i.op inside {op_andi, op_andis}) cw = 1'b1;
		disp_u.send(i);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			#1;
		end while (!res_valid_reg && n < 100);
		// the pulse is read just after the edge that raises it, one edge before the unit's own sample
		chk(64'(n + 1), 64'(lat));
		chk(fxr_we_reg, fxw);
		chk(gpr_we_reg, !cmpop);
		chk(cond_we_reg, cw || cmpop);
		if (!cmpop) begin
			chk(gpr_data_reg, r);
			chk(gpr_index_reg, i.dst);
		end
		if (fxw && i.oe) begin
			chk(result_exceeded_flag_reg, ovf);
			chk(so_flag_reg, so_x);
		end
		if (i.op == op_srad) chk(propagated_borrow_flag_reg, cry);
		if (cmpop) begin
			chk(cond_index_reg, i.tgt);
			chk(cond_field_reg, {sgn ? $signed(x) < $signed(y) : x < y,
				sgn ? $signed(x) > $signed(y) : x > y, x == y, i.so});
		end else if (cw) begin
			chk(cond_index_reg, `IEU_FIRST_FIELD);
			chk(cond_field_reg, {r[63], !r[63] && r != 0, r == 0, fxw && i.oe ? so_x : i.so});
		end
	endtask

	initial begin
		ieu_inst_t i;
		seed_val = $urandom(32'hDFAA7D24);
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk({busy_reg, res_valid_reg, gpr_we_reg, fxr_we_reg, cond_we_reg}, 64'h0);
		chk(gpr_data_reg, `IEU_RES_RST);
		foreach (op_list[j]) begin
			for (int k = 0; k < 6; k++) begin
				i = '0;
				i.op = op_list[j];
				{i.rec, i.oe, i.lng, i.so, i.ovf, i.cry, i.dst, i.tgt} = 14'($urandom);
				{i.imm, i.rot_amt, i.mbeg, i.mend} = 34'({$urandom, $urandom});
				i.opa = {$urandom, $urandom};
				i.opb = {$urandom, $urandom};
				i.ops = {$urandom, $urandom};
				if (!(i.op inside {op_add, op_subf, op_mulld, op_divd, op_divdu, op_mullw, op_divw,
					op_divwu})) i.oe = 1'b0;
				if (k == 0) begin
					i.opa = (i.op inside {op_mullw, op_divw, op_divwu}) ? `IEU_WORD_MIN : `IEU_DWORD_MIN;
					i.opb = ~64'h0;
				end
				if (k == 1) i.opb = 64'h0;
				if (k == 2) i.opb = i.opa;
				run(i);
			end
		end
		wrap_up;
	end
endmodule // testbench
